// *** sir_pkg.sv ***
// package of the system id and reset-cause register bank: offsets, layouts, reset values
// assumes a 32-bit apb slave with a 12-bit byte address inside the system block
package sir_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam logic [31:0] SYSTEM_BLOCK_BASE = 32'h5000_0000;

  // register byte offsets from the system block base
  localparam logic [11:0] OFS_PART_IDENTITY = 12'h000;
  localparam logic [11:0] OFS_RESET_CAUSE = 12'h004;
  localparam logic [11:0] OFS_BLOCK_RESET_CTRL_ONE = 12'h008;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h060;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h064;
  localparam logic [11:0] OFS_WRITE_UNLOCK = 12'h100;

  // plain read/write words kept as storage, in index order
  localparam int unsigned STORE_N = 11;
  localparam logic [11:0] STORE_OFS [STORE_N] = '{
    12'h00c, 12'h010, 12'h018, 12'h01c, 12'h024, 12'h030,
    12'h034, 12'h038, 12'h03c, 12'h040, 12'h050};
  localparam logic [31:0] STORE_RESET = 32'h0000_0000;

  // part identity: value is arbitrary, tied off per variant at build time
  localparam logic [31:0] PART_IDENTITY_DEFAULT = 32'h0000_a5c3;

  // reset-cause flag positions
  localparam int unsigned CAUSE_W = 8;
  localparam int unsigned POWER_ON_FLAG = 0;
  localparam int unsigned PIN_RESET_FLAG = 1;
  localparam int unsigned WATCHDOG_FLAG = 2;
  localparam int unsigned LOW_VOLTAGE_FLAG = 3;
  localparam int unsigned BROWNOUT_FLAG = 4;
  localparam int unsigned CORE_REQUEST_FLAG = 5;
  localparam int unsigned CORE_RESET_FLAG = 7;
  localparam logic [7:0] CAUSE_VALID_MASK = 8'hbf;
  localparam logic [7:0] CAUSE_POR_VALUE = 8'h01;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // block_reset_ctrl_one fields
  localparam int unsigned CTRL_ONE_W = 4;
  localparam int unsigned CTRL_CHIP_RST = 0;
  localparam int unsigned CTRL_CORE_RST = 1;
  localparam int unsigned CTRL_DMA_RST = 2;
  localparam int unsigned CTRL_EBI_RST = 3;
  localparam logic [3:0] CTRL_ONE_RESET = 4'h0;

  // core one-shot reset length in cycles
  localparam logic [1:0] CORE_PULSE_CYCLES = 2'h2;
  localparam logic [1:0] CORE_PULSE_LAST = CORE_PULSE_CYCLES - 2'h1;

  // unlock key sequence
  localparam logic [7:0] UNLOCK_KEY1 = 8'h59;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h16;
  localparam logic [7:0] UNLOCK_KEY3 = 8'h88;

  typedef enum logic [3:0] {
    UNL_LOCKED = 4'b0001,
    UNL_KEY1 = 4'b0010,
    UNL_KEY2 = 4'b0100,
    UNL_OPEN = 4'b1000
  } sir_unlock_e;

  // reset requests from the sources outside this block, levels
  typedef struct packed {
    logic core_sysreset_request;
    logic brownout;
    logic low_voltage;
    logic watchdog;
    logic pin;
  } sir_cause_src_s;

  // storage lookup: {hit, index}
  function automatic logic [4:0] sir_store_find(input logic [11:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < STORE_N; i++) begin
      if (addr == STORE_OFS[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : sir_store_find

endpackage : sir_pkg

// *** sir_regs.sv ***
// system id and reset-cause register bank with apb slave, write unlock and interrupt
// assumes por_n is low whenever presetn is low at power-up, cause sources are async levels
//
// Contract
// - part identity is a 32-bit read-only word holding the part number code.
// - part identity value is a build-time constant per variant, never written.
// - writing the core one-shot reset bit sets the core reset flag, bit 7.
// - writing 1 to a cause flag clears it; writing 0 leaves it.
// - core system reset request sets bit 5.
// - brown-out detector reset sets bit 4.
// - low-voltage reset unit sets bit 3.
// - reset cause leaves reset with cause flags in low byte, upper bits zero.
// - write unlock register decodes at offset 0x100 beside the other registers.
// - watchdog reset sets bit 2.
// - reset pin sets bit 1.
// - power-on reset or whole-chip reset bit sets bit 0.
// - core one-shot reset bit clears itself after two clock cycles.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module sir_regs #(
  parameter logic [31:0] PART_IDENTITY = sir_pkg::PART_IDENTITY_DEFAULT
) (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sir_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset sources
  input wire sir_pkg::sir_cause_src_s cause_src,
  // reset controls and interrupt
  output logic chip_reset,
  output logic core_reset,
  output logic dma_reset,
  output logic ebi_reset,
  output logic irq
);

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [7:0] cause_ff;
  logic [7:0] irq_status_ff;
  logic [7:0] irq_mask_ff;
  logic [3:0] ctrl_one_ff;
  logic [1:0] core_cnt_ff;
  logic [31:0] store_ff [sir_pkg::STORE_N];
  sir_pkg::sir_unlock_e unlock_ff;
  sir_pkg::sir_unlock_e nxt_unlock;

  // apb phases: zero-wait slave, pready high in the first access cycle
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite & pready_ff;
  wire [7:0] wdata_lo = pwdata[7:0];

  // address decode
  wire hit_part = paddr == sir_pkg::OFS_PART_IDENTITY;
  wire hit_cause = paddr == sir_pkg::OFS_RESET_CAUSE;
  wire hit_ctrl = paddr == sir_pkg::OFS_BLOCK_RESET_CTRL_ONE;
  wire hit_ists = paddr == sir_pkg::OFS_IRQ_STATUS;
  wire hit_imsk = paddr == sir_pkg::OFS_IRQ_MASK;
  wire hit_unlock = paddr == sir_pkg::OFS_WRITE_UNLOCK;
  wire [4:0] store_sel = sir_pkg::sir_store_find(paddr);
  wire hit_store = store_sel[4];
  wire [3:0] store_idx = store_sel[3:0];
  wire addr_hit = hit_part | hit_cause | hit_ctrl | hit_ists | hit_imsk | hit_unlock | hit_store;

  wire wr_cause = apb_wr & hit_cause;
  wire wr_ctrl = apb_wr & hit_ctrl;
  wire wr_unlock = apb_wr & hit_unlock;
  wire unlock_open = unlock_ff == sir_pkg::UNL_OPEN;
  wire ctrl_wr = wr_ctrl & unlock_open;

  // read mux; cause and interrupt registers sit in the low byte, rest zero
  wire [31:0] rd_data =
    hit_part ? PART_IDENTITY :
    hit_cause ? {24'h00_0000, cause_ff & sir_pkg::CAUSE_VALID_MASK} :
    hit_ctrl ? {28'h000_0000, ctrl_one_ff} :
    hit_ists ? {24'h00_0000, irq_status_ff} :
    hit_imsk ? {24'h00_0000, irq_mask_ff} :
    hit_unlock ? {31'h0000_0000, unlock_open} :
    hit_store ? store_ff[store_idx] : 32'h0000_0000;

  // cause set terms: protected writes to the reset control and synchronised sources
  wire core_set = ctrl_wr & pwdata[sir_pkg::CTRL_CORE_RST];
  wire chip_set = ctrl_wr & pwdata[sir_pkg::CTRL_CHIP_RST];
  wire [7:0] cause_set = {
    core_set,
    1'b0,
    sync2_ff[4],
    sync2_ff[3],
    sync2_ff[2],
    sync2_ff[1],
    sync2_ff[0],
    chip_set};
  wire [7:0] cause_clr = wr_cause ? wdata_lo : 8'h00;
  // set wins over a clear in the same cycle
  wire [7:0] nxt_cause = ((cause_ff & ~cause_clr) | cause_set) & sir_pkg::CAUSE_VALID_MASK;
  wire [7:0] cause_rise = nxt_cause & ~cause_ff;

  wire [7:0] ists_clr = (apb_wr & hit_ists) ? wdata_lo : 8'h00;
  wire [7:0] nxt_irq_status = (irq_status_ff & ~ists_clr) | cause_rise;

  // core one-shot: the bit drops on its own after the pulse length
  wire core_done = ctrl_one_ff[sir_pkg::CTRL_CORE_RST] & (core_cnt_ff == sir_pkg::CORE_PULSE_LAST);
  wire [3:0] ctrl_base = ctrl_wr ? pwdata[3:0] : ctrl_one_ff;
  wire [3:0] core_mask = 4'(1 << sir_pkg::CTRL_CORE_RST);
  wire [3:0] nxt_ctrl_one = core_done ? (ctrl_base & ~core_mask) : ctrl_base;
  wire [1:0] nxt_core_cnt = (ctrl_one_ff[sir_pkg::CTRL_CORE_RST] & ~core_done) ?
    core_cnt_ff + 2'h1 : 2'h0;

  // unlock sequence; any write to the unlock register while open locks again
  always_comb begin
    nxt_unlock = unlock_ff;
    if (wr_unlock) begin
      case (unlock_ff)
        sir_pkg::UNL_LOCKED: nxt_unlock = (wdata_lo == sir_pkg::UNLOCK_KEY1) ?
          sir_pkg::UNL_KEY1 : sir_pkg::UNL_LOCKED;
        sir_pkg::UNL_KEY1: nxt_unlock = (wdata_lo == sir_pkg::UNLOCK_KEY2) ?
          sir_pkg::UNL_KEY2 : sir_pkg::UNL_LOCKED;
        sir_pkg::UNL_KEY2: nxt_unlock = (wdata_lo == sir_pkg::UNLOCK_KEY3) ?
          sir_pkg::UNL_OPEN : sir_pkg::UNL_LOCKED;
        sir_pkg::UNL_OPEN: nxt_unlock = sir_pkg::UNL_LOCKED;
        default: nxt_unlock = sir_pkg::UNL_LOCKED;
      endcase
    end
  end

  // source synchronisers and cause flags live on the power-on reset only
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      cause_ff <= sir_pkg::CAUSE_POR_VALUE;
    end else begin
      sync1_ff <= cause_src;
      sync2_ff <= sync1_ff;
      cause_ff <= nxt_cause;
    end
  end

  // apb response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup & ~addr_hit;
      if (apb_setup & ~pwrite) begin
        prdata_ff <= rd_data;
      end
    end
  end

  // control, unlock and interrupt state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one_ff <= sir_pkg::CTRL_ONE_RESET;
      core_cnt_ff <= 2'h0;
      unlock_ff <= sir_pkg::UNL_LOCKED;
      irq_status_ff <= sir_pkg::IRQ_RESET;
      irq_mask_ff <= sir_pkg::IRQ_RESET;
      irq_ff <= 1'b0;
    end else begin
      ctrl_one_ff <= nxt_ctrl_one;
      core_cnt_ff <= nxt_core_cnt;
      unlock_ff <= nxt_unlock;
      irq_status_ff <= nxt_irq_status;
      if (apb_wr & hit_imsk) begin
        irq_mask_ff <= wdata_lo;
      end
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // plain read/write words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < sir_pkg::STORE_N; i++) begin
        store_ff[i] <= sir_pkg::STORE_RESET;
      end
    end else if (apb_wr & hit_store) begin
      store_ff[store_idx] <= pwdata;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign chip_reset = ctrl_one_ff[sir_pkg::CTRL_CHIP_RST];
  assign core_reset = ctrl_one_ff[sir_pkg::CTRL_CORE_RST];
  assign dma_reset = ctrl_one_ff[sir_pkg::CTRL_DMA_RST];
  assign ebi_reset = ctrl_one_ff[sir_pkg::CTRL_EBI_RST];

  // checks
  part_id_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup && !pwrite && hit_part) |=> (prdata_ff == PART_IDENTITY) && pready_ff)
    else $error("part identity read wrong");

  core_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    core_set |=> cause_ff[sir_pkg::CORE_RESET_FLAG] && core_reset)
    else $error("core one-shot did not flag core reset");

  cause_w1c_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    wr_cause |=> ((cause_ff & $past(wdata_lo) & ~$past(cause_set)) == 8'h00))
    else $error("cause flag not cleared by write one");

  cause_keep_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    (wr_cause && wdata_lo == 8'h00) |=> ((cause_ff & $past(cause_ff)) == $past(cause_ff)))
    else $error("cause flag lost on write zero");

  sysreq_flag_a: assert property (@(posedge pclk) disable iff (!por_n)
    sync2_ff[4] |=> cause_ff[sir_pkg::CORE_REQUEST_FLAG])
    else $error("core request flag not set");

  brownout_flag_a: assert property (@(posedge pclk) disable iff (!por_n)
    $rose(cause_src.brownout) ##1 cause_src.brownout |=> ##1 cause_ff[sir_pkg::BROWNOUT_FLAG])
    else $error("brownout flag not set within sync delay");

  lowvolt_flag_a: assert property (@(posedge pclk) disable iff (!por_n)
    sync2_ff[2] |=> cause_ff[sir_pkg::LOW_VOLTAGE_FLAG])
    else $error("low voltage flag not set");

  watchdog_flag_a: assert property (@(posedge pclk) disable iff (!por_n)
    sync2_ff[1] |=> cause_ff[sir_pkg::WATCHDOG_FLAG])
    else $error("watchdog flag not set");

  pin_flag_a: assert property (@(posedge pclk) disable iff (!por_n)
    sync2_ff[0] |=> cause_ff[sir_pkg::PIN_RESET_FLAG])
    else $error("pin reset flag not set");

  chip_flag_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    chip_set |=> cause_ff[sir_pkg::POWER_ON_FLAG])
    else $error("chip reset did not flag power-on");

  core_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_reset) |-> core_reset ##1 core_reset ##1 !core_reset)
    else $error("core one-shot not two cycles");

  unlock_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_unlock && unlock_ff == sir_pkg::UNL_KEY2 && wdata_lo == sir_pkg::UNLOCK_KEY3)
    |=> unlock_open)
    else $error("unlock sequence did not open");

  ctrl_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !unlock_open && !core_done) |=> $stable(ctrl_one_ff))
    else $error("protected control written while locked");

  cause_reserved_a: assert property (@(posedge pclk) disable iff (!por_n)
    (cause_ff & ~sir_pkg::CAUSE_VALID_MASK) == 8'h00)
    else $error("reserved cause bit set");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (irq == |($past(irq_status_ff) & $past(irq_mask_ff))))
    else $error("irq does not follow masked status");

  pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup |=> pready_ff)
    else $error("pready missing after setup");

  pready_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    !apb_setup |=> !pready_ff)
    else $error("pready without setup");

  slverr_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup && !addr_hit) |=> pslverr_ff && pready_ff)
    else $error("unmapped access without error");

  slverr_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(apb_setup && !addr_hit) |=> !pslverr_ff)
    else $error("error on mapped access");

  read_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup && !pwrite && !addr_hit) |=> (prdata_ff == 32'h0000_0000))
    else $error("unmapped read not zero");

  prdata_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(apb_setup && !pwrite) |=> $stable(prdata_ff))
    else $error("read data changed outside a read");

  cause_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup && !pwrite && hit_cause) |=> ((prdata_ff & 32'hffff_ff40) == 32'h0000_0000))
    else $error("reserved cause bits read nonzero");

  cause_presetn_a: assert property (@(posedge pclk) disable iff (!por_n)
    !presetn |=> ((cause_ff & $past(cause_ff)) == $past(cause_ff)))
    else $error("cause flag lost in bus reset");

  cause_sticky_a: assert property (@(posedge pclk) disable iff (!por_n)
    !wr_cause |=> ((cause_ff & $past(cause_ff)) == $past(cause_ff)))
    else $error("cause flag dropped without a clear");

  cause_set_a: assert property (@(posedge pclk) disable iff (!por_n)
    (cause_set != 8'h00) |=> ((cause_ff & $past(cause_set)) == $past(cause_set)))
    else $error("cause set lost against a clear");

  ists_set_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
    ($past(presetn) && $rose(cause_ff[sir_pkg::WATCHDOG_FLAG]))
    |-> irq_status_ff[sir_pkg::WATCHDOG_FLAG])
    else $error("status bit not set on new flag");

  ists_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && hit_ists)
    |=> ((irq_status_ff & $past(wdata_lo) & ~$past(cause_rise)) == 8'h00))
    else $error("status bit not cleared by write one");

  ists_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(apb_wr && hit_ists)
    |=> ((irq_status_ff & $past(irq_status_ff)) == $past(irq_status_ff)))
    else $error("status bit dropped without a clear");

  mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && hit_imsk) |=> (irq_mask_ff == $past(wdata_lo)))
    else $error("mask write lost");

  ctrl_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_wr
    |=> ({ebi_reset, dma_reset, chip_reset} == $past({ebi_reset, dma_reset, chip_reset})))
    else $error("reset control moved without an open write");

  ctrl_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && !core_done)
    |=> ({ebi_reset, dma_reset, core_reset, chip_reset} == $past(pwdata[3:0])))
    else $error("open control write lost");

  core_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_reset ##1 core_reset |=> !core_reset)
    else $error("core one-shot longer than two cycles");

  core_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
    !core_reset |-> (core_cnt_ff == 2'h0))
    else $error("one-shot counter running while idle");

  unlock_relock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_unlock && unlock_open) |=> !unlock_open)
    else $error("write while open did not relock");

  unlock_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_unlock && unlock_ff != sir_pkg::UNL_KEY2) |=> !unlock_open)
    else $error("unlock opened out of order");

  unlock_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup && !pwrite && hit_unlock) |=> (prdata_ff == {31'h0000_0000, unlock_open}))
    else $error("unlock state read wrong");

  irq_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_mask_ff == 8'h00) |=> !irq)
    else $error("irq raised with all sources masked");

  watchdog_sync_a: assert property (@(posedge pclk) disable iff (!por_n)
    cause_src.watchdog ##1 cause_src.watchdog ##1 cause_src.watchdog
    |=> cause_ff[sir_pkg::WATCHDOG_FLAG])
    else $error("watchdog level not flagged after sync delay");

  read_cause_c: cover property (@(posedge pclk) disable iff (!presetn)
    apb_setup && !pwrite && hit_cause ##1 pready_ff);
  core_shot_c: cover property (@(posedge pclk) disable iff (!presetn)
    core_set ##1 core_reset ##2 !core_reset);
  unlock_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(unlock_open));
  irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  slverr_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(pslverr_ff));

endmodule : sir_regs

// *** system_id_reset_cause_regs_tb_top.sv ***
// self-checking bench of the system id and reset-cause register bank
// assumes sir_regs with its package; the bench is apb master and drives the reset sources
`timescale 1ns/1ps
module system_id_reset_cause_regs_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic por_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sir_pkg::sir_cause_src_s cause_src = '0;
  logic chip_reset, core_reset, dma_reset, ebi_reset, irq;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] exp_cause;
  logic [31:0] mem [int];
  logic [31:0] rdat;
  logic rerr;
  int n;

  always #2.5 pclk = ~pclk;

  sir_regs uut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cause_src(cause_src), .chip_reset(chip_reset),
    .core_reset(core_reset), .dma_reset(dma_reset), .ebi_reset(ebi_reset), .irq(irq));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      $display("[FAIL] %0t apb answer timeout", $time);
      end_sim();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rdat, exp, "read data");
    check({31'h0, rerr}, 32'h0000_0000, "slave error");
  endtask : rd

  // a stray byte relocks first, so the key sequence opens from any state
  task automatic unlock();
    apb(1'b1, sir_pkg::OFS_WRITE_UNLOCK, 32'h0000_0000);
    apb(1'b1, sir_pkg::OFS_WRITE_UNLOCK, {24'h0, sir_pkg::UNLOCK_KEY1});
    apb(1'b1, sir_pkg::OFS_WRITE_UNLOCK, {24'h0, sir_pkg::UNLOCK_KEY2});
    apb(1'b1, sir_pkg::OFS_WRITE_UNLOCK, {24'h0, sir_pkg::UNLOCK_KEY3});
  endtask : unlock

  // raise one source level for a few cycles; flag bit is source index plus one
  task automatic pulse_src(input int i);
    @(posedge pclk);
    cause_src <= sir_pkg::sir_cause_src_s'(5'h01 << i);
    repeat (4) @(posedge pclk);
    cause_src <= '0;
    repeat (4) @(posedge pclk);
    exp_cause[i + 1] = 1'b1;
  endtask : pulse_src

  initial begin
    void'($urandom(32'h08ad6c74));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    exp_cause = sir_pkg::CAUSE_POR_VALUE;
    rd(sir_pkg::OFS_PART_IDENTITY, sir_pkg::PART_IDENTITY_DEFAULT);
    apb(1'b1, sir_pkg::OFS_PART_IDENTITY, 32'hffff_ffff);
    rd(sir_pkg::OFS_PART_IDENTITY, sir_pkg::PART_IDENTITY_DEFAULT);
    rd(sir_pkg::OFS_RESET_CAUSE, {24'h0, exp_cause});
    apb(1'b1, sir_pkg::OFS_RESET_CAUSE, 32'h0000_0000);
    rd(sir_pkg::OFS_RESET_CAUSE, {24'h0, exp_cause});
    apb(1'b1, sir_pkg::OFS_RESET_CAUSE, 32'hffff_ffff);
    exp_cause = 8'h00;
    rd(sir_pkg::OFS_RESET_CAUSE, 32'h0000_0000);
    $display("test identity and clear done");
    for (int i = 0; i < 5; i++) begin
      pulse_src(i);
      rd(sir_pkg::OFS_RESET_CAUSE, {24'h0, exp_cause});
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(sir_pkg::OFS_RESET_CAUSE, {24'h0, exp_cause});
    apb(1'b1, sir_pkg::OFS_RESET_CAUSE, 32'h0000_0014);
    exp_cause = exp_cause & ~8'h14;
    rd(sir_pkg::OFS_RESET_CAUSE, {24'h0, exp_cause});
    apb(1'b1, sir_pkg::OFS_RESET_CAUSE, 32'h0000_00ff);
    exp_cause = 8'h00;
    $display("test cause sources done");
    apb(1'b1, sir_pkg::OFS_BLOCK_RESET_CTRL_ONE, 32'h0000_000f);
    @(negedge pclk);
    check({28'h0, ebi_reset, dma_reset, core_reset, chip_reset}, 32'h0, "locked write");
    unlock();
    rd(sir_pkg::OFS_WRITE_UNLOCK, 32'h0000_0001);
    apb(1'b1, sir_pkg::OFS_BLOCK_RESET_CTRL_ONE, 32'h0000_0002);
    n = 0;
    repeat (6) begin
      @(negedge pclk);
      if (core_reset === 1'b1) n++;
    end
    check(n, 2, "core pulse length");
    exp_cause[sir_pkg::CORE_RESET_FLAG] = 1'b1;
    rd(sir_pkg::OFS_RESET_CAUSE, {24'h0, exp_cause});
    rd(sir_pkg::OFS_BLOCK_RESET_CTRL_ONE, 32'h0000_0000);
    unlock();
    apb(1'b1, sir_pkg::OFS_BLOCK_RESET_CTRL_ONE, 32'h0000_0001);
    @(negedge pclk);
    check({31'h0, chip_reset}, 32'h1, "chip reset level");
    exp_cause[sir_pkg::POWER_ON_FLAG] = 1'b1;
    rd(sir_pkg::OFS_RESET_CAUSE, {24'h0, exp_cause});
    unlock();
    apb(1'b1, sir_pkg::OFS_BLOCK_RESET_CTRL_ONE, 32'h0000_0000);
    @(negedge pclk);
    check({31'h0, chip_reset}, 32'h0, "chip reset release");
    $display("test reset controls done");
    apb(1'b1, sir_pkg::OFS_RESET_CAUSE, 32'h0000_00ff);
    apb(1'b1, sir_pkg::OFS_IRQ_STATUS, 32'h0000_00ff);
    apb(1'b1, sir_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    pulse_src(1);
    @(negedge pclk);
    check({31'h0, irq}, 32'h1, "irq raised");
    rd(sir_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    apb(1'b1, sir_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    repeat (2) @(negedge pclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    apb(1'b1, sir_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, sir_pkg::OFS_RESET_CAUSE, 32'h0000_0004);
    pulse_src(1);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0, "irq masked");
    rd(sir_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    $display("test interrupt done");
    for (int i = 0; i < sir_pkg::STORE_N; i++) begin
      mem[i] = $urandom();
      apb(1'b1, sir_pkg::STORE_OFS[i], mem[i]);
    end
    for (int i = 0; i < sir_pkg::STORE_N; i++) begin
      rd(sir_pkg::STORE_OFS[i], mem[i]);
    end
    apb(1'b0, 12'hff4, 32'h0000_0000);
    check({31'h0, rerr}, 32'h1, "unmapped error");
    check(rdat, 32'h0000_0000, "unmapped data");
    $display("test storage done");
    end_sim();
  end
endmodule : system_id_reset_cause_regs_tb_top
